// ### core/twesc_map.svh
// twesc_map.svh: offsets, field positions, codes and timing figures of the eeprom target
// assumes: included by its bare name from the package and the core
`ifndef TWESC_MAP_SVH
`define TWESC_MAP_SVH

// array geometry
`define TWESC_ADDR_W 15
`define TWESC_MEM_BYTES 32768
`define TWESC_PAGE_BYTES 64
`define TWESC_OFF_W 6
`define TWESC_OFF_MSB 5
`define TWESC_ROW_MSB 14
`define TWESC_ROW_LSB 6
`define TWESC_AHI_MSB 6
`define TWESC_AHI_LSB 8

// serial framing
`define TWESC_LAST_BIT 4'h7
`define TWESC_ACK_SLOT 4'h8
`define TWESC_DEV_CODE 4'ha
`define TWESC_CODE_MSB 7
`define TWESC_CODE_LSB 4
`define TWESC_SEL_MSB 3
`define TWESC_SEL_LSB 1
`define TWESC_RW_BIT 0

// synchroniser lanes
`define TWESC_SYNC_W 7
`define TWESC_SY_TGL 6
`define TWESC_SY_SCL 5
`define TWESC_SY_SDA 4
`define TWESC_SY_WP 3
`define TWESC_SY_SEL_MSB 2
`define TWESC_SY_SEL_LSB 0

// programming cycle timing
`define TWESC_TWR_NS 5000000
`define TWESC_CLK_NS 20
`define TWESC_PROG_W 24

// write buffer
`define TWESC_FIFO_DEPTH 8
`define TWESC_FIFO_W 14

`endif

// ### core/twesc_pkg.sv
// twesc_pkg: phase encoding and state records of the eeprom target
// assumes: twesc_map.svh gives the address, page, program counter and synchroniser widths used here
`include "twesc_map.svh"

package twesc_pkg;

    typedef enum logic [5:0] {
        ph_idle = 6'h01,
        ph_dev = 6'h02,
        ph_ahi = 6'h04,
        ph_alo = 6'h08,
        ph_wdat = 6'h10,
        ph_rdat = 6'h20
    } twesc_phase_e;

    typedef struct packed {
        logic bit_val;
        logic tgl;
    } twesc_link_s;

    typedef struct packed {
        twesc_phase_e phase;
        logic [3:0] cnt;
        logic [7:0] shift;
        logic [7:0] tx;
        logic [`TWESC_ADDR_W-1:0] addr;
        logic ack;
        logic sda_oe;
        logic [`TWESC_PAGE_BYTES-1:0] mask;
        logic [`TWESC_PAGE_BYTES-1:0][7:0] page;
        logic pending;
        logic busy;
        logic [`TWESC_PROG_W-1:0] prog_cnt;
        logic [`TWESC_SYNC_W-1:0] sy1;
        logic [`TWESC_SYNC_W-1:0] sy2;
        logic [`TWESC_SYNC_W-1:0] sy3;
        logic [`TWESC_SYNC_W-1:0] filt;
    } twesc_sys_s;

endpackage

// ### core/twesc_fifo.sv
// twesc_fifo: small first-in first-out buffer, flip-flop storage, valid/ready both sides
// assumes: DEPTH is a power of two; one clock, asynchronous active-high reset
`timescale 1ns/1ns
`default_nettype none
`include "twesc_map.svh"

module twesc_fifo #(
    parameter int WIDTH = `TWESC_FIFO_W,
    parameter int DEPTH = `TWESC_FIFO_DEPTH
) (
    input wire logic clk_sys_in,
    input wire logic reset_in,
    input wire logic in_valid_in,
    output logic in_ready_out,
    input wire logic [WIDTH-1:0] in_data_in,
    output logic out_valid_out,
    input wire logic out_ready_in,
    output logic [WIDTH-1:0] out_data_out
);

    localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [PW-1:0] rd;
        logic [PW-1:0] wr;
        logic [PW:0] count;
    } twesc_fifo_s;

    twesc_fifo_s fs;
    twesc_fifo_s next_fs;
    logic push;
    logic pop;

    // honest flags: full refuses, empty offers nothing
    assign in_ready_out = (fs.count != (PW+1)'(DEPTH));
    assign out_valid_out = (fs.count != '0);
    assign out_data_out = fs.mem[fs.rd];
    assign push = in_valid_in && in_ready_out;
    assign pop = out_valid_out && out_ready_in;

    always_comb
    begin
        next_fs = fs;
        if (push)
        begin
            next_fs.mem[fs.wr] = in_data_in;
            next_fs.wr = fs.wr + PW'(1);
        end
        if (pop)
        begin
            next_fs.rd = fs.rd + PW'(1);
        end
        if (push && !pop)
        begin
            next_fs.count = fs.count + (PW+1)'(1);
        end
        else if (pop && !push)
        begin
            next_fs.count = fs.count - (PW+1)'(1);
        end
    end

    always_ff @(posedge clk_sys_in or posedge reset_in)
    begin
        if (reset_in)
        begin
            fs <= '0;
        end
        else
        begin
            fs <= next_fs;
        end
    end

endmodule

`default_nettype wire

// ### core/twesc_core.sv
// twesc_core: target side of a two-wire serial eeprom, array, page buffer, self-timed program
// assumes: bus pull-up on the data line; pads pull floating select and inhibit pins low
// Contract
// - capture on clock rise, change on fall
// - data line only pulled low or released
// - answer only when select bits match pins
// - floating select pins read as low
// - inhibit low: writes performed normally
// - inhibit high: no program cycle starts; a running one still commits
// - floating inhibit pin reads as low
// - 512 pages of 64 bytes, row on top
// - 15-bit word address picks one byte
// - page writes of one to 64 bytes
// - self-timed program cycle within 5 ms
// - detect start and stop conditions
// - eight bits, ack low on ninth clock
// - last address bit selects read or write
// - page write wraps low six address bits
`timescale 1ns/1ns
`default_nettype none
`include "twesc_map.svh"

module twesc_core #(
    parameter int unsigned PROG_CYCLES = `TWESC_TWR_NS / `TWESC_CLK_NS,
    parameter int FIFO_DEPTH = `TWESC_FIFO_DEPTH
) (
    input wire logic clk_sys_in,
    input wire logic reset_in,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe_out,
    input wire logic bus_select_bit0_in,
    input wire logic bus_select_bit1_in,
    input wire logic bus_select_bit2_in,
    input wire logic write_inhibit_in,
    output logic prog_busy_out
);

    twesc_pkg::twesc_link_s lk;
    twesc_pkg::twesc_link_s next_lk;
    twesc_pkg::twesc_sys_s st;
    twesc_pkg::twesc_sys_s next_st;

    logic [7:0] mem [0:`TWESC_MEM_BYTES-1];
    logic [7:0] mem_rd;
    logic [`TWESC_SYNC_W-1:0] pins;
    logic [`TWESC_SYNC_W-1:0] settled;
    logic bit_ev;
    logic scl_fall;
    logic start_ev;
    logic stop_ev;
    logic inhibit;
    logic [2:0] select;
    logic [7:0] rx_byte;
    logic commit;
    logic push;
    logic [`TWESC_FIFO_W-1:0] push_data;
    logic push_ready;
    logic pop_valid;
    logic pop_ready;
    logic [`TWESC_FIFO_W-1:0] pop_data;

    // a lane only moves once the second and third stages agree
    function automatic logic [`TWESC_SYNC_W-1:0] settle(
        input logic [`TWESC_SYNC_W-1:0] s2,
        input logic [`TWESC_SYNC_W-1:0] s3,
        input logic [`TWESC_SYNC_W-1:0] held
    );
        settle = (~(s2 ^ s3) & s3) | ((s2 ^ s3) & held);
    endfunction

    // link domain: the serial clock itself samples the data line
    always_comb
    begin
        next_lk = lk;
        next_lk.bit_val = sda_in;
        next_lk.tgl = ~lk.tgl;
    end

    // link clock stops between frames; the toggle carries each bit over
    always_ff @(posedge scl_in or posedge reset_in)
    begin
        if (reset_in)
        begin
            lk <= '0;
        end
        else
        begin
            lk <= next_lk;
        end
    end

    // pins and the link toggle enter the system clock through three stages
    assign pins = {lk.tgl, scl_in, sda_in, write_inhibit_in,
                   bus_select_bit2_in, bus_select_bit1_in, bus_select_bit0_in};
    assign settled = settle(st.sy2, st.sy3, st.filt);
    // floating pins are held low by the pad, so no extra term here
    assign inhibit = st.filt[`TWESC_SY_WP];
    assign select = st.filt[`TWESC_SY_SEL_MSB:`TWESC_SY_SEL_LSB];
    assign bit_ev = settled[`TWESC_SY_TGL] ^ st.filt[`TWESC_SY_TGL];
    assign scl_fall = st.filt[`TWESC_SY_SCL] && !settled[`TWESC_SY_SCL];
    assign start_ev = st.filt[`TWESC_SY_SCL] && settled[`TWESC_SY_SCL]
                      && st.filt[`TWESC_SY_SDA] && !settled[`TWESC_SY_SDA];
    assign stop_ev = st.filt[`TWESC_SY_SCL] && settled[`TWESC_SY_SCL]
                     && !st.filt[`TWESC_SY_SDA] && settled[`TWESC_SY_SDA];
    assign rx_byte = {st.shift[6:0], lk.bit_val};
    assign mem_rd = mem[st.addr];

    // the write buffer only drains while no program cycle runs
    assign pop_ready = !st.busy;
    assign commit = st.busy && (st.prog_cnt == `TWESC_PROG_W'(PROG_CYCLES - 1));

    always_comb
    begin
        next_st = st;
        push = 1'b0;
        push_data = {st.addr[`TWESC_OFF_MSB:0], rx_byte};
        next_st.sy1 = pins;
        next_st.sy2 = st.sy1;
        next_st.sy3 = st.sy2;
        next_st.filt = settled;

        if (start_ev)
        begin
            next_st.phase = twesc_pkg::ph_dev;
            next_st.cnt = '0;
            next_st.ack = 1'b0;
            next_st.sda_oe = 1'b0;
            if (!st.busy && !st.pending)
            begin
                // leftovers of an aborted write never reach the array
                next_st.mask = '0;
            end
        end
        else if (stop_ev)
        begin
            next_st.phase = twesc_pkg::ph_idle;
            next_st.cnt = '0;
            next_st.ack = 1'b0;
            next_st.sda_oe = 1'b0;
            if (st.phase == twesc_pkg::ph_wdat)
            begin
                if (!inhibit)
                begin
                    next_st.pending = 1'b1;
                end
                else
                begin
                    next_st.mask = '0;
                end
            end
        end
        else if (bit_ev && (st.phase != twesc_pkg::ph_idle))
        begin
            if (st.cnt != `TWESC_ACK_SLOT)
            begin
                next_st.shift = rx_byte;
                next_st.cnt = st.cnt + 4'h1;
                if (st.cnt == `TWESC_LAST_BIT)
                begin
                    case (st.phase)
                        twesc_pkg::ph_dev:
                        begin
                            next_st.ack = (rx_byte[`TWESC_CODE_MSB:`TWESC_CODE_LSB] == `TWESC_DEV_CODE)
                                          && (rx_byte[`TWESC_SEL_MSB:`TWESC_SEL_LSB] == select)
                                          && !st.busy;
                            if (next_st.ack && rx_byte[`TWESC_RW_BIT])
                            begin
                                next_st.tx = mem_rd;
                                next_st.addr = st.addr + `TWESC_ADDR_W'(1);
                            end
                        end
                        twesc_pkg::ph_ahi:
                        begin
                            next_st.ack = 1'b1;
                            next_st.addr[`TWESC_ROW_MSB:`TWESC_AHI_LSB] = rx_byte[`TWESC_AHI_MSB:0];
                        end
                        twesc_pkg::ph_alo:
                        begin
                            next_st.ack = 1'b1;
                            next_st.addr[`TWESC_AHI_LSB-1:0] = rx_byte;
                        end
                        twesc_pkg::ph_wdat:
                        begin
                            // inhibited bytes are acked and dropped
                            next_st.ack = inhibit || push_ready;
                            push = !inhibit && push_ready;
                            if (next_st.ack)
                            begin
                                next_st.addr[`TWESC_OFF_MSB:0] = st.addr[`TWESC_OFF_MSB:0]
                                                                 + `TWESC_OFF_W'(1);
                            end
                        end
                        twesc_pkg::ph_rdat:
                        begin
                            next_st.ack = 1'b0;
                        end
                        default:
                        begin
                            next_st.ack = 1'b0;
                        end
                    endcase
                end
            end
            else
            begin
                next_st.cnt = '0;
                case (st.phase)
                    twesc_pkg::ph_dev:
                    begin
                        if (!st.ack)
                        begin
                            next_st.phase = twesc_pkg::ph_idle;
                        end
                        else if (st.shift[`TWESC_RW_BIT])
                        begin
                            next_st.phase = twesc_pkg::ph_rdat;
                        end
                        else
                        begin
                            next_st.phase = twesc_pkg::ph_ahi;
                        end
                    end
                    twesc_pkg::ph_ahi:
                    begin
                        next_st.phase = twesc_pkg::ph_alo;
                    end
                    twesc_pkg::ph_alo:
                    begin
                        next_st.phase = twesc_pkg::ph_wdat;
                    end
                    twesc_pkg::ph_wdat:
                    begin
                        next_st.phase = st.ack ? twesc_pkg::ph_wdat : twesc_pkg::ph_idle;
                    end
                    twesc_pkg::ph_rdat:
                    begin
                        // controller ack keeps the sequential read going
                        if (!lk.bit_val)
                        begin
                            next_st.tx = mem_rd;
                            next_st.addr = st.addr + `TWESC_ADDR_W'(1);
                        end
                        else
                        begin
                            next_st.phase = twesc_pkg::ph_idle;
                        end
                    end
                    default:
                    begin
                        next_st.phase = twesc_pkg::ph_idle;
                    end
                endcase
            end
        end
        else if (scl_fall)
        begin
            if ((st.phase != twesc_pkg::ph_idle) && (st.phase != twesc_pkg::ph_rdat)
                && (st.cnt == `TWESC_ACK_SLOT) && st.ack)
            begin
                next_st.sda_oe = 1'b1;
            end
            else if ((st.phase == twesc_pkg::ph_rdat) && (st.cnt != `TWESC_ACK_SLOT))
            begin
                next_st.sda_oe = ~st.tx[~st.cnt[2:0]];
            end
            else
            begin
                next_st.sda_oe = 1'b0;
            end
        end

        // buffered bytes land in the page latch at their offset
        if (pop_valid && pop_ready)
        begin
            next_st.page[pop_data[`TWESC_FIFO_W-1:8]] = pop_data[7:0];
            next_st.mask[pop_data[`TWESC_FIFO_W-1:8]] = 1'b1;
        end

        // program only once the buffer has emptied into the latch
        if (st.pending && !st.busy && !pop_valid)
        begin
            next_st.pending = 1'b0;
            next_st.busy = (st.mask != '0) && !inhibit;
            next_st.prog_cnt = '0;
            if (inhibit)
            begin
                next_st.mask = '0;
            end
        end
        else if (st.busy)
        begin
            next_st.prog_cnt = st.prog_cnt + `TWESC_PROG_W'(1);
            if (commit)
            begin
                next_st.busy = 1'b0;
                next_st.mask = '0;
            end
        end
    end

    always_ff @(posedge clk_sys_in or posedge reset_in)
    begin
        if (reset_in)
        begin
            st <= '0;
            st.phase <= twesc_pkg::ph_idle;
        end
        else
        begin
            st <= next_st;
        end
    end

    // array: the row is the upper address, the latch fills the offsets
    always_ff @(posedge clk_sys_in)
    begin
        if (commit)
        begin
            for (int i = 0; i < `TWESC_PAGE_BYTES; i++)
            begin
                if (st.mask[i])
                begin
                    mem[{st.addr[`TWESC_ROW_MSB:`TWESC_ROW_LSB], `TWESC_OFF_W'(i)}] <= st.page[i];
                end
            end
        end
    end

    twesc_fifo #(
        .WIDTH(`TWESC_FIFO_W),
        .DEPTH(FIFO_DEPTH)
    ) u_wbuf (
        .clk_sys_in(clk_sys_in),
        .reset_in(reset_in),
        .in_valid_in(push),
        .in_ready_out(push_ready),
        .in_data_in(push_data),
        .out_valid_out(pop_valid),
        .out_ready_in(pop_ready),
        .out_data_out(pop_data)
    );

    // open drain: the pin level is always low, only the enable moves
    assign sda_out = 1'b0;
    assign sda_oe_out = st.sda_oe;
    assign prog_busy_out = st.busy;

endmodule

`default_nettype wire

// ### tb/twesc_core_properties.sv
// twesc_core_properties: timing checks of the eeprom target seen at its top ports
// assumes: bound into twesc_core; one system clock, asynchronous active-high reset
`timescale 1ns/1ns
`default_nettype none

module twesc_core_properties #(
    parameter int unsigned PROG_CYCLES = 250000
) (
    input wire logic clk_sys_in,
    input wire logic reset_in,
    input wire logic scl_in,
    input wire logic sda_in,
    input wire logic sda_out,
    input wire logic sda_oe_out,
    input wire logic bus_select_bit0_in,
    input wire logic bus_select_bit1_in,
    input wire logic bus_select_bit2_in,
    input wire logic write_inhibit_in,
    input wire logic prog_busy_out
);
    logic [31:0] busy_cnt;

    // counts cycles of the running program cycle, cleared between cycles
    always_ff @(posedge clk_sys_in or posedge reset_in)
    begin
        if (reset_in)
            busy_cnt <= 32'h0;
        else
            busy_cnt <= prog_busy_out ? busy_cnt + 32'h1 : 32'h0;
    end

    default clocking cb @(posedge clk_sys_in);
    endclocking
    default disable iff (reset_in);

    data_low_only_a:
        assert property (sda_out == 1'b0)
        else $error("data output value not low");
    change_on_fall_a:
        assert property ($changed(sda_oe_out) |-> !scl_in &&
            ($past(scl_in, 3) || $past(scl_in, 4) || $past(scl_in, 5) || $past(scl_in, 6) || $past(scl_in, 7)))
        else $error("data output changed away from a clock fall");
    ack_holds_high_a:
        assert property ($rose(scl_in) && sda_oe_out |-> sda_oe_out [*8])
        else $error("pull-down dropped while clock high");
    busy_silent_a:
        assert property (prog_busy_out |-> !$rose(sda_oe_out))
        else $error("answered during program cycle");
    prog_after_stop_a:
        assert property ($rose(prog_busy_out) |-> scl_in && sda_in)
        else $error("program cycle began outside a stop");
    inhibit_no_prog_a:
        assert property ($rose(prog_busy_out) |-> !$past(write_inhibit_in, 8))
        else $error("program cycle while writes inhibited");
    prog_bound_a:
        assert property (prog_busy_out |-> busy_cnt <= PROG_CYCLES + 1)
        else $error("program cycle overran");
    prog_length_a:
        assert property ($fell(prog_busy_out) |-> busy_cnt + 1 >= PROG_CYCLES && busy_cnt <= PROG_CYCLES + 1)
        else $error("program cycle length wrong");
    reset_quiet_a:
        assert property ($fell(reset_in) |-> !sda_oe_out && !prog_busy_out)
        else $error("outputs active after reset");

    cover property ($rose(prog_busy_out));
    cover property ($rose(sda_oe_out));
    cover property ($fell(prog_busy_out));
endmodule

bind twesc_core twesc_core_properties #(.PROG_CYCLES(PROG_CYCLES)) props (
    .clk_sys_in(clk_sys_in),
    .reset_in(reset_in),
    .scl_in(scl_in),
    .sda_in(sda_in),
    .sda_out(sda_out),
    .sda_oe_out(sda_oe_out),
    .bus_select_bit0_in(bus_select_bit0_in),
    .bus_select_bit1_in(bus_select_bit1_in),
    .bus_select_bit2_in(bus_select_bit2_in),
    .write_inhibit_in(write_inhibit_in),
    .prog_busy_out(prog_busy_out)
);

`default_nettype wire

// ### tb/twesc_ctl_model.sv
// twesc_ctl_model: behavioural two-wire bus controller, makes the clock and pulls data low
// assumes: data wire has a pull-up; tasks step on falling edges of the system clock
`timescale 1ns/1ns
`default_nettype none

module twesc_ctl_model #(
    parameter int HALF = 25
) (
    input wire logic clk_sys_in,
    input wire logic sda_in,
    output logic scl_out,
    output logic sda_low_out
);
    // clock stands high between frames; 25 cycles a half gives the 1 MHz ceiling
    initial
    begin
        scl_out = 1'b1;
        sda_low_out = 1'b0;
    end

    task automatic hold(input int n);
        repeat (n) @(negedge clk_sys_in);
    endtask

    task automatic start();
        hold(2);
        sda_low_out = 1'b0;
        hold(HALF);
        scl_out = 1'b1;
        hold(HALF);
        sda_low_out = 1'b1;
        hold(HALF);
        scl_out = 1'b0;
    endtask

    task automatic stop();
        hold(2);
        sda_low_out = 1'b1;
        hold(HALF);
        scl_out = 1'b1;
        hold(HALF);
        sda_low_out = 1'b0;
        hold(HALF);
    endtask

    // data moves two cycles after the fall so it never races the clock edge
    task automatic bitx(input logic b, output logic r);
        hold(2);
        sda_low_out = ~b;
        hold(HALF);
        scl_out = 1'b1;
        hold(HALF);
        r = sda_in;
        scl_out = 1'b0;
    endtask

    task automatic wbyte(input logic [7:0] b, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--)
            bitx(b[i], r);
        bitx(1'b1, ack);
    endtask

    task automatic rbyte(input logic last, output logic [7:0] b);
        logic r;
        for (int i = 7; i >= 0; i--)
            bitx(1'b1, b[i]);
        bitx(last, r);
    endtask
endmodule

`default_nettype wire

// ### tb/two_wire_eeprom_slave_core_bench.sv
// two_wire_eeprom_slave_core_bench: self-checking bench of the eeprom target
// assumes: core, fifo and controller model compiled first; program cycle shortened
`timescale 1ns/1ns
`default_nettype none
`include "twesc_map.svh"

module two_wire_eeprom_slave_core_bench;
    localparam int PROG = 800;
    logic clk_sys_in;
    logic reset_in;
    logic scl;
    logic ctl_low;
    logic sda_out;
    logic sda_oe_out;
    logic prog_busy_out;
    logic [2:0] sel;
    logic inhibit;
    logic [7:0] model [0:32767];
    wire sda_wire;
    int err_count;
    int cmp_count;
    int busy_n;

    assign sda_wire = ~(ctl_low | (sda_oe_out & ~sda_out));

    twesc_core #(.PROG_CYCLES(PROG), .FIFO_DEPTH(8)) dut (
        .clk_sys_in(clk_sys_in),
        .reset_in(reset_in),
        .scl_in(scl),
        .sda_in(sda_wire),
        .sda_out(sda_out),
        .sda_oe_out(sda_oe_out),
        .bus_select_bit0_in(sel[0]),
        .bus_select_bit1_in(sel[1]),
        .bus_select_bit2_in(sel[2]),
        .write_inhibit_in(inhibit),
        .prog_busy_out(prog_busy_out)
    );

    twesc_ctl_model ctl (
        .clk_sys_in(clk_sys_in),
        .sda_in(sda_wire),
        .scl_out(scl),
        .sda_low_out(ctl_low)
    );

    initial
    begin
        clk_sys_in = 1'b0;
        forever #10 clk_sys_in = ~clk_sys_in;
    end

    always @(posedge clk_sys_in)
        if (prog_busy_out === 1'b1)
            busy_n++;

    task automatic results();
        $display("comparisons %0d mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            err_count++;
            $display("FAIL at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic put(input logic [7:0] d, input logic nack);
        logic ack;
        ctl.wbyte(d, ack);
        chk({7'h00, ack}, {7'h00, nack});
    endtask

    task automatic addr_w(input logic [14:0] a);
        ctl.start();
        put({`TWESC_DEV_CODE, sel, 1'b0}, 1'b0);
        put({1'b0, a[14:8]}, 1'b0);
        put(a[7:0], 1'b0);
    endtask

    task automatic wr(input logic [14:0] a, input int n, input logic [7:0] base, input logic prog);
        logic [14:0] p;
        int b0;
        addr_w(a);
        for (int i = 0; i < n; i++)
        begin
            p = {a[14:6], a[5:0] + i[5:0]};
            put(base + i[7:0], 1'b0);
            if (!inhibit)
                model[p] = base + i[7:0];
        end
        b0 = busy_n;
        ctl.stop();
        chk({7'h00, prog_busy_out}, {7'h00, prog});
        if (prog)
        begin
            // polling while programming must go unanswered
            ctl.start();
            put({`TWESC_DEV_CODE, sel, 1'b0}, 1'b1);
            ctl.stop();
            for (int k = 0; k < PROG + 50 && prog_busy_out !== 1'b0; k++)
                @(negedge clk_sys_in);
            // a program cycle that never ends is a hang, not a late pass
            if (prog_busy_out !== 1'b0)
            begin
                err_count++;
                $display("FAIL at %0t: program cycle never ended", $time);
                results();
            end
            chk({7'h00, (busy_n - b0 >= PROG - 1) && (busy_n - b0 <= PROG + 1)}, 8'h01);
        end
    endtask

    task automatic rd(input logic [14:0] a, input int n);
        logic [7:0] b;
        logic [14:0] p;
        addr_w(a);
        ctl.start();
        put({`TWESC_DEV_CODE, sel, 1'b1}, 1'b0);
        for (int i = 0; i < n; i++)
        begin
            p = a + i[14:0];
            ctl.rbyte(i == n - 1, b);
            chk(b, model[p]);
        end
        ctl.stop();
    endtask

    task automatic t_byte();
        wr(15'h0000, 1, 8'h5a, 1'b1);
        rd(15'h0000, 1);
        $display("test byte write done");
    endtask

    // partial page from offset 62 wraps to the page start; read wraps the whole array
    task automatic t_page_wrap();
        wr(15'h7ffe, 4, 8'ha0, 1'b1);
        rd(15'h7fc0, 2);
        rd(15'h7ffe, 3);
        $display("test page wrap done");
    endtask

    task automatic t_wrong_sel();
        logic [7:0] b;
        rd(15'h7fff, 1);
        ctl.start();
        put({4'h5, sel, 1'b1}, 1'b1);
        ctl.stop();
        for (int s = 0; s < 8; s++)
        begin
            ctl.start();
            put({`TWESC_DEV_CODE, s[2:0], 1'b1}, s[2:0] != sel);
            if (s[2:0] == sel)
            begin
                ctl.rbyte(1'b1, b);
                chk(b, model[15'h0000]);
            end
            ctl.stop();
        end
        $display("test select match done");
    endtask

    task automatic t_inhibit();
        inhibit = 1'b1;
        wr(15'h0000, 1, 8'hc3, 1'b0);
        rd(15'h0000, 1);
        inhibit = 1'b0;
        $display("test write inhibit done");
    endtask

    // watchdog cuts any hang short
    initial
    begin
        repeat (100000) @(posedge clk_sys_in);
        err_count++;
        results();
    end

    initial
    begin
        err_count = 0;
        cmp_count = 0;
        busy_n = 0;
        reset_in = 1'b1;
        sel = 3'h5;
        inhibit = 1'b0;
        repeat (5) @(negedge clk_sys_in);
        reset_in = 1'b0;
        repeat (5) @(negedge clk_sys_in);
        t_byte();
        t_page_wrap();
        t_wrong_sel();
        t_inhibit();
        results();
    end
endmodule

`default_nettype wire
